/* logic/oag_defines.svh */
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH
// Address and data widths
`define OAG_DW 8
`define OAG_AW 16
// Reset values
`define OAG_RST_BYTE 8'h00
`define OAG_RST_ADDR 16'h0000
// Direct page upper byte when the page select flag is clear
`define OAG_PAGE_ZERO 8'h00
// Index step of the auto-increment mode
`define OAG_X_STEP 8'h01
// Pointer high byte sits one location above the low byte
`define OAG_PTR_STEP 8'h01
`endif

/* logic/oag_pkg.sv */
package oag_pkg;
  typedef enum logic [3:0] {
    OAG_M_REG,
    OAG_M_IMM,
    OAG_M_DP,
    OAG_M_ABS,
    OAG_M_ABS_RMW,
    OAG_M_X_INC,
    OAG_M_X,
    OAG_M_DP_X,
    OAG_M_DP_Y,
    OAG_M_ABS_Y,
    OAG_M_IND_DP,
    OAG_M_IND_DP_X,
    OAG_M_IND_DP_Y,
    OAG_M_IND_ABS
  } oag_mode_t;

  typedef enum logic [2:0] {
    OAG_R_ACC,
    OAG_R_X,
    OAG_R_Y,
    OAG_R_CARRY,
    OAG_R_PSW
  } oag_reg_sel_t;

  // One decoded request from the fetch stream
  typedef struct packed {
    oag_mode_t    mode;
    oag_reg_sel_t reg_sel;
    logic [7:0]   op1;
    logic [7:0]   op2;
  } oag_req_t;

  // CPU state the address depends on
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] x;
    logic [7:0] y;
    logic       carry;
    logic [7:0] processor_status_word;
    logic [7:0] ram_page_register;
    logic       page_sel;
  } oag_cpu_t;

  // Result handed to the execute stage
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  value;
    logic        is_value;
    logic        is_target;
  } oag_res_t;
endpackage : oag_pkg

/* logic/oag_dp_addr.sv */
`timescale 1ns/1ns
`include "oag_defines.svh"
// Direct page address former: 8-bit offset wraps inside the page
module oag_dp_addr (
  input  wire logic [7:0]  base_in,
  input  wire logic [7:0]  index_in,
  input  wire logic [7:0]  page_in,
  input  wire logic        page_sel_in,
  output logic      [15:0] addr_out
);
  logic [7:0] low;
  logic [7:0] high;

  // Sum truncated to 8 bits so the access never leaves the page
  assign low  = 8'(base_in + index_in);
  assign high = page_sel_in ? page_in : `OAG_PAGE_ZERO;
  assign addr_out = {high, low};
endmodule : oag_dp_addr

/* logic/oag_ptr_fetch.sv */
`timescale 1ns/1ns
`include "oag_defines.svh"
// Two-byte pointer reader: low byte first, then high byte
module oag_ptr_fetch (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        start_in,
  input  wire logic [15:0] lo_addr_in,
  input  wire logic [15:0] hi_addr_in,
  input  wire logic        mem_ready_in,
  input  wire logic [7:0]  mem_rdata_in,
  output logic             mem_req_out,
  output logic      [15:0] mem_addr_out,
  output logic             done_out,
  output logic      [15:0] ptr_out
);
  typedef enum logic [1:0] {P_IDLE, P_LO, P_HI} oag_pstate_t;
  oag_pstate_t state;
  logic [15:0] hi_addr;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state        <= P_IDLE;
      mem_req_out  <= 1'b0;
      mem_addr_out <= `OAG_RST_ADDR;
      hi_addr      <= `OAG_RST_ADDR;
      ptr_out      <= `OAG_RST_ADDR;
      done_out     <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (state)
        P_IDLE: begin
          if (start_in) begin
            mem_req_out  <= 1'b1;
            mem_addr_out <= lo_addr_in;
            hi_addr      <= hi_addr_in;
            state        <= P_LO;
          end
        end
        P_LO: begin
          if (mem_ready_in) begin
            ptr_out[7:0] <= mem_rdata_in;
            mem_addr_out <= hi_addr;
            state        <= P_HI;
          end
        end
        P_HI: begin
          if (mem_ready_in) begin
            ptr_out[15:8] <= mem_rdata_in;
            mem_req_out   <= 1'b0;
            done_out      <= 1'b1;
            state         <= P_IDLE;
          end
        end
      endcase
    end
  end
endmodule : oag_ptr_fetch

/* logic/oag_addr_gen.sv */
`timescale 1ns/1ns
`include "oag_defines.svh"
// Operation
// - Register mode takes A, X, Y, carry or status word, no memory access.
// - Immediate mode uses the second byte as the operand value.
// - With page select set, address is page register over operand byte.
// - Direct page mode uses the operand byte as offset in the page.
// - Absolute mode: second byte is low address, third byte high.
// - Three-byte absolute instruction reaches the whole memory space.
// - Absolute read-modify-write ops ignore page select and page register.
// - Auto-increment mode addresses page location X, then hands X plus one back for X.
// - Indexed mode without offset addresses X within the direct page.
// - Operand plus X addresses a location within the direct page.
// - Operand plus Y addresses a location within the direct page.
// - Absolute address plus Y reaches the whole memory space.
// - Direct page indirect reads a byte pair as jump or call target.
// - Operand plus X locates a 16-bit pointer, low byte first.
// - Pointer at operand location, then Y added, forms the data address.
// - Absolute indirect fetches new program counter from the absolute pair.
module oag_addr_gen (
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_N_IN,
  input  wire logic                  REQ_VALID_IN,
  input  wire oag_pkg::oag_req_t     REQ_IN,
  input  wire oag_pkg::oag_cpu_t     CPU_IN,
  input  wire logic                  MEM_READY_IN,
  input  wire logic [7:0]            MEM_RDATA_IN,
  output logic                       BUSY_OUT,
  output logic                       MEM_REQ_OUT,
  output logic      [15:0]           MEM_ADDR_OUT,
  output logic                       RES_VALID_OUT,
  output oag_pkg::oag_res_t          RES_OUT,
  output logic                       X_WE_OUT,
  output logic      [7:0]            X_NEXT_OUT
);
  // ----------------------------------------------------------------
  // Combinational address forming
  // ----------------------------------------------------------------
  oag_pkg::oag_req_t req;
  oag_pkg::oag_cpu_t cpu;
  logic [15:0]       dp_base;
  logic [15:0]       dp_x;
  logic [15:0]       dp_y;
  logic [15:0]       dp_ptr_lo;
  logic [15:0]       dp_ptr_hi;
  logic [15:0]       abs_addr;
  logic [15:0]       abs_hi;
  logic [7:0]        ptr_lo_off;
  logic [7:0]        ptr_hi_off;
  logic [7:0]        reg_value;

  assign req = REQ_IN;
  assign cpu = CPU_IN;
  assign abs_addr = {req.op2, req.op1};
  // Carry from the low byte reaches the upper byte of the absolute pointer
  assign abs_hi   = 16'(abs_addr + 16'h0001);

  // ----------------------------------------------------------------
  // Direct page adders
  // ----------------------------------------------------------------
  oag_dp_addr u_dp_base (
    .base_in     (req.op1),
    .index_in    (8'h00),
    .page_in     (cpu.ram_page_register),
    .page_sel_in (cpu.page_sel),
    .addr_out    (dp_base)
  );

  // The X-only forms share this adder with a zero operand
  oag_dp_addr u_dp_x (
    .base_in     ((req.mode == oag_pkg::OAG_M_DP_X ||
                   req.mode == oag_pkg::OAG_M_IND_DP_X) ? req.op1 : 8'h00),
    .index_in    (cpu.x),
    .page_in     (cpu.ram_page_register),
    .page_sel_in (cpu.page_sel),
    .addr_out    (dp_x)
  );

  oag_dp_addr u_dp_y (
    .base_in     (req.op1),
    .index_in    (cpu.y),
    .page_in     (cpu.ram_page_register),
    .page_sel_in (cpu.page_sel),
    .addr_out    (dp_y)
  );

  // Pointer offset: operand, or operand plus X for the X form
  assign ptr_lo_off = (req.mode == oag_pkg::OAG_M_IND_DP_X) ?
                      8'(req.op1 + cpu.x) : req.op1;
  assign ptr_hi_off = 8'(ptr_lo_off + `OAG_PTR_STEP);

  oag_dp_addr u_ptr_lo (
    .base_in     (ptr_lo_off),
    .index_in    (8'h00),
    .page_in     (cpu.ram_page_register),
    .page_sel_in (cpu.page_sel),
    .addr_out    (dp_ptr_lo)
  );

  oag_dp_addr u_ptr_hi (
    .base_in     (ptr_hi_off),
    .index_in    (8'h00),
    .page_in     (cpu.ram_page_register),
    .page_sel_in (cpu.page_sel),
    .addr_out    (dp_ptr_hi)
  );

  // ----------------------------------------------------------------
  // Register operand
  // ----------------------------------------------------------------
  // Carry is widened with zeros to fill the byte
  always_comb begin
    unique case (req.reg_sel)
      oag_pkg::OAG_R_ACC:   reg_value = cpu.acc;
      oag_pkg::OAG_R_X:     reg_value = cpu.x;
      oag_pkg::OAG_R_Y:     reg_value = cpu.y;
      oag_pkg::OAG_R_CARRY: reg_value = {7'h00, cpu.carry};
      oag_pkg::OAG_R_PSW:   reg_value = cpu.processor_status_word;
      default:              reg_value = `OAG_RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic take;
  logic is_ind;
  logic is_jump;
  logic is_x_inc;
  logic adds_y;

  // Requests are taken only while no pointer fetch runs
  assign take = REQ_VALID_IN && !BUSY_OUT;

  // Codes past the last mode decode as plain forms with no memory access
  always_comb begin
    is_ind   = 1'b0;
    is_jump  = 1'b0;
    is_x_inc = 1'b0;
    adds_y   = 1'b0;
    unique case (req.mode)
      oag_pkg::OAG_M_X_INC: is_x_inc = 1'b1;
      oag_pkg::OAG_M_IND_DP: begin
        is_ind  = 1'b1;
        is_jump = 1'b1;
      end
      oag_pkg::OAG_M_IND_DP_X: is_ind = 1'b1;
      oag_pkg::OAG_M_IND_DP_Y: begin
        is_ind = 1'b1;
        adds_y = 1'b1;
      end
      oag_pkg::OAG_M_IND_ABS: begin
        is_ind  = 1'b1;
        is_jump = 1'b1;
      end
      default: is_ind = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Pointer reader
  // ----------------------------------------------------------------
  logic        ptr_start;
  logic        ptr_done;
  logic [15:0] ptr_val;
  logic [15:0] ptr_lo_addr;
  logic [15:0] ptr_hi_addr;

  assign ptr_start   = take && is_ind;
  // Absolute indirect reads its pair anywhere in the 16-bit space
  assign ptr_lo_addr = (req.mode == oag_pkg::OAG_M_IND_ABS) ? abs_addr : dp_ptr_lo;
  assign ptr_hi_addr = (req.mode == oag_pkg::OAG_M_IND_ABS) ? abs_hi : dp_ptr_hi;

  // Memory pins come straight from the reader's flops; a further stage
  // would lag the ready it watches and pair a byte with the wrong address
  oag_ptr_fetch u_ptr (
    .CLK_IN       (CLK_IN),
    .RST_N_IN     (RST_N_IN),
    .start_in     (ptr_start),
    .lo_addr_in   (ptr_lo_addr),
    .hi_addr_in   (ptr_hi_addr),
    .mem_ready_in (MEM_READY_IN),
    .mem_rdata_in (MEM_RDATA_IN),
    .mem_req_out  (MEM_REQ_OUT),
    .mem_addr_out (MEM_ADDR_OUT),
    .done_out     (ptr_done),
    .ptr_out      (ptr_val)
  );

  // ----------------------------------------------------------------
  // Pending pointer request
  // ----------------------------------------------------------------
  logic       pend_jump;
  logic       pend_add_y;
  logic [7:0] pend_y;

  // Y is held from the take so a later change of Y cannot move the result
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pend_jump  <= 1'b0;
      pend_add_y <= 1'b0;
      pend_y     <= `OAG_RST_BYTE;
    end else if (ptr_start) begin
      pend_jump  <= is_jump;
      pend_add_y <= adds_y;
      pend_y     <= cpu.y;
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  oag_pkg::oag_res_t next_res;

  always_comb begin
    next_res = '0;
    unique case (req.mode)
      oag_pkg::OAG_M_REG: begin
        next_res.value    = reg_value;
        next_res.is_value = 1'b1;
      end
      oag_pkg::OAG_M_IMM: begin
        next_res.value    = req.op1;
        next_res.is_value = 1'b1;
      end
      oag_pkg::OAG_M_DP:      next_res.addr = dp_base;
      oag_pkg::OAG_M_ABS:     next_res.addr = abs_addr;
      oag_pkg::OAG_M_ABS_RMW: next_res.addr = abs_addr;
      oag_pkg::OAG_M_X_INC:   next_res.addr = dp_x;
      oag_pkg::OAG_M_X:       next_res.addr = dp_x;
      oag_pkg::OAG_M_DP_X:    next_res.addr = dp_x;
      oag_pkg::OAG_M_DP_Y:    next_res.addr = dp_y;
      oag_pkg::OAG_M_ABS_Y:   next_res.addr = 16'(abs_addr + {8'h00, cpu.y});
      default:                next_res.addr = `OAG_RST_ADDR;
    endcase
  end

  // One-cycle strobe; RES_OUT holds until the next result
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RES_VALID_OUT <= 1'b0;
    end else begin
      RES_VALID_OUT <= (take && !is_ind) || ptr_done;
    end
  end

  // Non-indirect results land one edge after the take
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RES_OUT <= '0;
    end else if (take && !is_ind) begin
      RES_OUT <= next_res;
    end else if (ptr_done) begin
      RES_OUT.value     <= `OAG_RST_BYTE;
      RES_OUT.is_value  <= 1'b0;
      // Jump forms hand the pointer over as a program counter
      RES_OUT.is_target <= pend_jump;
      RES_OUT.addr      <= pend_add_y ?
                           16'(ptr_val + {8'h00, pend_y}) : ptr_val;
    end
  end

  // ----------------------------------------------------------------
  // Busy flag
  // ----------------------------------------------------------------
  // BUSY falls on the edge that raises the pointer result, so a request
  // held through the fetch is taken one edge after the result at the earliest
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      BUSY_OUT <= 1'b0;
    end else if (ptr_start) begin
      BUSY_OUT <= 1'b1;
    end else if (ptr_done) begin
      BUSY_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Index write-back
  // ----------------------------------------------------------------
  // Strobe one edge after the take; X itself lives in the core
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      X_WE_OUT <= 1'b0;
    end else begin
      X_WE_OUT <= take && is_x_inc;
    end
  end

  // Follows X every cycle and matters only with the strobe
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      X_NEXT_OUT <= `OAG_RST_BYTE;
    end else begin
      X_NEXT_OUT <= 8'(cpu.x + `OAG_X_STEP);
    end
  end
endmodule : oag_addr_gen

/* tb/oag_addr_gen_properties.sv */
`timescale 1ns/1ns
module oag_addr_gen_checker (
  input wire logic              CLK_IN,
  input wire logic              RST_N_IN,
  input wire logic              REQ_VALID_IN,
  input wire oag_pkg::oag_req_t REQ_IN,
  input wire oag_pkg::oag_cpu_t CPU_IN,
  input wire logic              BUSY_OUT,
  input wire logic              MEM_REQ_OUT,
  input wire logic              RES_VALID_OUT,
  input wire oag_pkg::oag_res_t RES_OUT,
  input wire logic              X_WE_OUT,
  input wire logic [7:0]        X_NEXT_OUT
);
  logic               take;
  logic               ind;
  oag_pkg::oag_mode_t md;
  assign take = REQ_VALID_IN && !BUSY_OUT;
  assign md   = REQ_IN.mode;
  assign ind  = md inside {oag_pkg::OAG_M_IND_DP, oag_pkg::OAG_M_IND_DP_X,
                           oag_pkg::OAG_M_IND_DP_Y, oag_pkg::OAG_M_IND_ABS};
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  reg_nomem_a: assert property (take && md == oag_pkg::OAG_M_REG
    |=> RES_VALID_OUT && RES_OUT.is_value && !MEM_REQ_OUT) else $error("register mode bad");
  imm_value_a: assert property (take && md == oag_pkg::OAG_M_IMM
    |=> RES_OUT.is_value && RES_OUT.value == $past(REQ_IN.op1)) else $error("immediate bad");
  dp_page_a: assert property (take && md == oag_pkg::OAG_M_DP
    |=> RES_OUT.addr == {($past(CPU_IN.page_sel) ? $past(CPU_IN.ram_page_register) : 8'h00),
    $past(REQ_IN.op1)}) else $error("direct page address bad");
  abs_addr_a: assert property (take && md inside {oag_pkg::OAG_M_ABS,
    oag_pkg::OAG_M_ABS_RMW} |=> RES_OUT.addr == {$past(REQ_IN.op2), $past(REQ_IN.op1)})
    else $error("absolute address bad");
  x_plain_a: assert property (take && md == oag_pkg::OAG_M_X
    |=> RES_OUT.addr[7:0] == $past(CPU_IN.x)) else $error("index address bad");
  dp_x_wrap_a: assert property (take && md == oag_pkg::OAG_M_DP_X
    |=> RES_OUT.addr[7:0] == 8'($past(REQ_IN.op1) + $past(CPU_IN.x))) else $error("dp+x bad");
  abs_y_a: assert property (take && md == oag_pkg::OAG_M_ABS_Y
    |=> RES_OUT.addr == 16'({$past(REQ_IN.op2), $past(REQ_IN.op1)} + $past(CPU_IN.y)))
    else $error("abs+y bad");
  x_inc_we_a: assert property (take && md == oag_pkg::OAG_M_X_INC |-> ##[1:2] X_WE_OUT)
    else $error("x increment missing");
  x_next_a: assert property (X_WE_OUT |-> X_NEXT_OUT == 8'($past(CPU_IN.x) + 8'h01))
    else $error("x next value bad");
  ind_busy_a: assert property (take && ind |=> BUSY_OUT
    ##[2:30] (RES_VALID_OUT && !BUSY_OUT)) else $error("pointer fetch did not finish");
endmodule : oag_addr_gen_checker

bind oag_addr_gen oag_addr_gen_checker u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN), .CPU_IN(CPU_IN), .BUSY_OUT(BUSY_OUT),
  .MEM_REQ_OUT(MEM_REQ_OUT), .RES_VALID_OUT(RES_VALID_OUT), .RES_OUT(RES_OUT),
  .X_WE_OUT(X_WE_OUT), .X_NEXT_OUT(X_NEXT_OUT));

/* tb/oag_mem_model.sv */
`timescale 1ns/1ns
module oag_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        req_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        slow_in,
  output logic             ready_out,
  output logic      [7:0]  rdata_out
);
  logic [1:0] wait_cnt;
  logic [7:0] last;
  // Slow mode holds each read off two cycles
  assign ready_out = req_in && (!slow_in || wait_cnt == 2'h2);
  // Idle bus shows the inverse of the last byte so stale data never matches
  assign rdata_out = ready_out ? (addr_in[7:0] ^ {addr_in[11:8], addr_in[15:12]} ^ 8'h5A) : ~last;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_cnt <= 2'h0;
      last     <= 8'h00;
    end else begin
      wait_cnt <= (req_in && !ready_out) ? wait_cnt + 2'h1 : 2'h0;
      if (ready_out) begin
        last <= rdata_out;
      end
    end
  end
endmodule : oag_mem_model

/* tb/tb_oag_addr_gen.sv */
`timescale 1ns/1ns
module tb_oag_addr_gen;
  logic              CLK_IN = 1'b0;
  logic              RST_N_IN = 1'b0;
  logic              REQ_VALID_IN = 1'b0;
  oag_pkg::oag_req_t REQ_IN = '0;
  oag_pkg::oag_cpu_t CPU_IN = '0;
  logic              MEM_READY_IN;
  logic [7:0]        MEM_RDATA_IN;
  logic              BUSY_OUT;
  logic              MEM_REQ_OUT;
  logic [15:0]       MEM_ADDR_OUT;
  logic              RES_VALID_OUT;
  oag_pkg::oag_res_t RES_OUT;
  logic              X_WE_OUT;
  logic [7:0]        X_NEXT_OUT;
  logic              slow = 1'b0;
  int                bad_count = 0;
  int                checked = 0;
  oag_pkg::oag_res_t exp_q[$];
  logic [7:0]        x_q[$];

  always #4 CLK_IN = ~CLK_IN;

  oag_addr_gen uut (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .REQ_VALID_IN(REQ_VALID_IN),
    .REQ_IN(REQ_IN), .CPU_IN(CPU_IN), .MEM_READY_IN(MEM_READY_IN), .MEM_RDATA_IN(MEM_RDATA_IN),
    .BUSY_OUT(BUSY_OUT), .MEM_REQ_OUT(MEM_REQ_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
    .RES_VALID_OUT(RES_VALID_OUT), .RES_OUT(RES_OUT), .X_WE_OUT(X_WE_OUT),
    .X_NEXT_OUT(X_NEXT_OUT));
  oag_mem_model u_mem (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .req_in(MEM_REQ_OUT),
    .addr_in(MEM_ADDR_OUT), .slow_in(slow), .ready_out(MEM_READY_IN), .rdata_out(MEM_RDATA_IN));

  // ------------------------------------------------------------
  // Expected results
  // ------------------------------------------------------------
  function automatic logic [15:0] ptr(input logic [15:0] lo, input logic [15:0] hi);
    return {hi[7:0] ^ {hi[11:8], hi[15:12]} ^ 8'h5A, lo[7:0] ^ {lo[11:8], lo[15:12]} ^ 8'h5A};
  endfunction : ptr

  function automatic oag_pkg::oag_res_t expect_res(input oag_pkg::oag_req_t r,
                                                   input oag_pkg::oag_cpu_t c);
    oag_pkg::oag_res_t e;
    logic [7:0]        pg;
    logic [15:0]       ab;
    e = '0;
    pg = c.page_sel ? c.ram_page_register : 8'h00;
    ab = {r.op2, r.op1};
    e.is_value = r.mode inside {oag_pkg::OAG_M_REG, oag_pkg::OAG_M_IMM};
    e.is_target = r.mode inside {oag_pkg::OAG_M_IND_DP, oag_pkg::OAG_M_IND_ABS};
    e.value = r.op1;
    case (r.reg_sel)
      oag_pkg::OAG_R_ACC: e.value = (r.mode == oag_pkg::OAG_M_REG) ? c.acc : r.op1;
      oag_pkg::OAG_R_X: e.value = (r.mode == oag_pkg::OAG_M_REG) ? c.x : r.op1;
      oag_pkg::OAG_R_Y: e.value = (r.mode == oag_pkg::OAG_M_REG) ? c.y : r.op1;
      oag_pkg::OAG_R_CARRY: e.value = (r.mode == oag_pkg::OAG_M_REG) ? {7'h00, c.carry} : r.op1;
      default: e.value = (r.mode == oag_pkg::OAG_M_REG) ? c.processor_status_word : r.op1;
    endcase
    case (r.mode)
      oag_pkg::OAG_M_DP: e.addr = {pg, r.op1};
      oag_pkg::OAG_M_ABS, oag_pkg::OAG_M_ABS_RMW: e.addr = ab;
      oag_pkg::OAG_M_X_INC, oag_pkg::OAG_M_X: e.addr = {pg, c.x};
      oag_pkg::OAG_M_DP_X: e.addr = {pg, 8'(r.op1 + c.x)};
      oag_pkg::OAG_M_DP_Y: e.addr = {pg, 8'(r.op1 + c.y)};
      oag_pkg::OAG_M_ABS_Y: e.addr = 16'(ab + c.y);
      oag_pkg::OAG_M_IND_DP: e.addr = ptr({pg, r.op1}, {pg, 8'(r.op1 + 8'h01)});
      oag_pkg::OAG_M_IND_DP_X: e.addr = ptr({pg, 8'(r.op1 + c.x)}, {pg, 8'(r.op1 + c.x + 8'h01)});
      oag_pkg::OAG_M_IND_DP_Y: e.addr = 16'(ptr({pg, r.op1}, {pg, 8'(r.op1 + 8'h01)}) + c.y);
      oag_pkg::OAG_M_IND_ABS: e.addr = ptr(ab, 16'(ab + 16'h0001));
      default: e.addr = 16'h0000;
    endcase
    return e;
  endfunction : expect_res

  task automatic cmp_res(input oag_pkg::oag_res_t e, input oag_pkg::oag_res_t g);
    checked++;
    if (!((g.is_value === e.is_value) && (g.is_target === e.is_target) &&
          (e.is_value ? g.value === e.value : g.addr === e.addr))) begin
      bad_count++;
      $display("wrong value RES_OUT expected %h seen %h", e, g);
    end
  endtask : cmp_res

  task automatic cmp_x(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value X_NEXT_OUT expected %h seen %h", e, g);
    end
  endtask : cmp_x

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Repeated request stays up while busy, so a second take shows as an extra result
  task automatic issue(input oag_pkg::oag_req_t r, input oag_pkg::oag_cpu_t c);
    int n;
    @(negedge CLK_IN);
    REQ_VALID_IN = 1'b1;
    REQ_IN = r;
    CPU_IN = c;
    exp_q.push_back(expect_res(r, c));
    if (r.mode == oag_pkg::OAG_M_X_INC) begin
      x_q.push_back(8'(c.x + 8'h01));
    end
    @(posedge CLK_IN);
    if (r.mode inside {[oag_pkg::OAG_M_IND_DP:oag_pkg::OAG_M_IND_ABS]}) begin
      n = 0;
      do begin
        @(negedge CLK_IN);
        n++;
      end while (BUSY_OUT !== 1'b0 && n < 40);
      REQ_VALID_IN = 1'b0;
      if (n == 40) begin
        bad_count++;
        $display("wrong value BUSY_OUT expected 0 seen %b", BUSY_OUT);
        results();
      end
    end
  endtask : issue

  always @(negedge CLK_IN) begin
    if (RES_VALID_OUT === 1'b1) begin
      if (exp_q.size() > 0) begin
        cmp_res(exp_q.pop_front(), RES_OUT);
      end else begin
        cmp_res('1, RES_OUT);
      end
    end
    if (X_WE_OUT === 1'b1) begin
      if (x_q.size() > 0) begin
        cmp_x(x_q.pop_front(), X_NEXT_OUT);
      end else begin
        bad_count++;
        $display("wrong value X_WE_OUT expected 0 seen %b", X_WE_OUT);
      end
    end
  end

  // ------------------------------------------------------------
  // Sequence: random rounds, then all-ones boundary rounds
  // ------------------------------------------------------------
  initial begin
    oag_pkg::oag_req_t r;
    oag_pkg::oag_cpu_t c;
    void'($urandom(32'hC749));
    repeat (10) @(posedge CLK_IN);
    @(negedge CLK_IN);
    RST_N_IN = 1'b1;
    for (int k = 0; k < 8; k++) begin
      slow = k[0];
      for (int m = 0; m < 14; m++) begin
        r = '{oag_pkg::oag_mode_t'(m), oag_pkg::oag_reg_sel_t'(k % 5), 8'($urandom), 8'($urandom)};
        c = oag_pkg::oag_cpu_t'(42'({$urandom, $urandom}));
        c.page_sel = k[1];
        if (k >= 6) begin
          {r.op1, r.op2, c.x, c.y} = 32'hFFFFFFFF;
        end
        issue(r, c);
      end
      $display("test round %0d done", k);
    end
    @(negedge CLK_IN);
    REQ_VALID_IN = 1'b0;
    for (int t = 0; t < 50 && (exp_q.size() > 0 || x_q.size() > 0); t++) begin
      @(negedge CLK_IN);
    end
    if (exp_q.size() > 0 || x_q.size() > 0) begin
      bad_count++;
      $display("wrong value RES_VALID_OUT expected 1 seen %b", RES_VALID_OUT);
    end
    results();
  end
endmodule : tb_oag_addr_gen
